// >>> src/async_timer2.sv
// Purpose: 8-bit timer with two compare channels, prescaler and optional timer-oscillator clocking.
// Assumes: APB slave, zero wait states; the oscillator pin may be unrelated to pclk.
// Notes: In asynchronous mode the pin's rising edges are the timer source ticks.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "timer2_defs.svh"

module async_timer2 #(
  parameter int PRESC_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`T2_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_osc_input_pin,
  output logic compare_output_pin_a,
  output logic compare_output_pin_b,
  output logic compare_a_pin_connected,
  output logic compare_b_pin_connected,
  output logic ext_clock_buffer_enable,
  output logic crystal_osc_enable,
  output logic irq_compare_a,
  output logic irq_compare_b,
  output logic irq_overflow
);

  // Bus decode.
  wire [9:0] idx = paddr[`T2_ADDR_W-1:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_mask = aligned && (idx == `T2_IDX_MASK);
  wire hit_flags = aligned && (idx == `T2_IDX_FLAGS);
  wire hit_ca = aligned && (idx == `T2_IDX_CTRL_A);
  wire hit_cb = aligned && (idx == `T2_IDX_CTRL_B);
  wire hit_cnt = aligned && (idx == `T2_IDX_COUNT);
  wire hit_oa = aligned && (idx == `T2_IDX_CMP_A);
  wire hit_ob = aligned && (idx == `T2_IDX_CMP_B);
  wire hit_as = aligned && (idx == `T2_IDX_ASYNC);
  wire hit_cpu = aligned && (idx == `T2_IDX_CPU);
  wire mapped = hit_mask | hit_flags | hit_ca | hit_cb | hit_cnt | hit_oa | hit_ob | hit_as | hit_cpu;
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite && mapped;
  wire [7:0] wd = pwdata[7:0];

  // Software-visible storage and active copies.
  logic [7:0] tmp_ca_ff;
  logic [7:0] tmp_cb_ff;
  logic [7:0] tmp_oa_ff;
  logic [7:0] tmp_ob_ff;
  logic [7:0] act_ca_ff;
  logic [7:0] act_cb_ff;
  logic [7:0] act_oa_ff;
  logic [7:0] act_ob_ff;
  logic [7:0] tmp_cnt_ff;
  logic [7:0] cnt_ff;
  logic up_ff;
  logic block_ff;
  logic [2:0] mask_ff;
  logic [2:0] flags_ff;
  logic global_ie_ff;
  logic ext_clk_ff;
  logic async_sel_ff;
  logic [4:0] busy_ff;
  logic [PRESC_W-1:0] presc_ff;
  logic osc_s1_ff;
  logic osc_s2_ff;
  logic osc_s3_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  timer2_pkg::wave_pins_t pins_ff;

  // Timer source: every pclk or a synchronised rising edge of the oscillator pin.
  // The pin passes two flops before the edge detector so a slow, unrelated
  // oscillator cannot make the detector see a half-settled level.
  wire osc_rise = osc_s2_ff && !osc_s3_ff;
  wire src_tick = async_sel_ff ? osc_rise : 1'b1;

  timer2_pkg::ctrl_a_t ca;
  assign ca = timer2_pkg::ctrl_a_t'(act_ca_ff);
  wire [2:0] wgm = {act_cb_ff[`T2_CTRLB_WGM_HI], ca.wgm_lo};
  wire [2:0] cs = act_cb_ff[2:0];

  timer2_pkg::wave_kind_t kind;
  assign kind = (wgm[1:0] == 2'b00) ? timer2_pkg::WAVE_NORMAL :
                (wgm[1:0] == 2'b10) ? timer2_pkg::WAVE_CTC :
                (wgm[1:0] == 2'b11) ? timer2_pkg::WAVE_FAST : timer2_pkg::WAVE_PHASE;
  // Non-PWM mode is judged on the active control copy, not the value being written.
  wire non_pwm = (kind == timer2_pkg::WAVE_NORMAL) || (kind == timer2_pkg::WAVE_CTC);

  // Prescaler taps.
  // The prescaler runs freely while a clock is selected, so the first divided
  // tick after a select change may come early; software cannot reset it here.
  logic presc_pulse;
  always_comb begin
    case (cs)
      3'd0: presc_pulse = 1'b0;
      3'd1: presc_pulse = 1'b1;
      3'd2: presc_pulse = &presc_ff[2:0];
      3'd3: presc_pulse = &presc_ff[4:0];
      3'd4: presc_pulse = &presc_ff[5:0];
      3'd5: presc_pulse = &presc_ff[6:0];
      3'd6: presc_pulse = &presc_ff[7:0];
      default: presc_pulse = &presc_ff[9:0];
    endcase
  end
  wire tick = src_tick && presc_pulse;

  // Phase-correct and fast modes turn at the compare register when wgm[2] is set, else at T2_MAX.
  wire [7:0] top = wgm[2] ? act_oa_ff : `T2_MAX;
  wire match_a = tick && !block_ff && (cnt_ff == act_oa_ff);
  wire match_b = tick && !block_ff && (cnt_ff == act_ob_ff);

  // Counter sequencing.
  // A tick evaluates the current count, so a match or turn seen at a tick
  // takes effect on that same edge and its flag is set on that same edge.
  logic [7:0] run_cnt;
  logic run_up;
  logic ovf;
  logic bottom_evt;
  always_comb begin
    run_cnt = cnt_ff + 8'h01;
    run_up = 1'b1;
    ovf = 1'b0;
    bottom_evt = 1'b0;
    case (kind)
      timer2_pkg::WAVE_NORMAL: begin
        ovf = (cnt_ff == `T2_MAX);
      end
      timer2_pkg::WAVE_CTC: begin
        ovf = (cnt_ff == `T2_MAX);
        if (cnt_ff == act_oa_ff) begin
          run_cnt = `T2_BOTTOM;
        end
      end
      timer2_pkg::WAVE_FAST: begin
        ovf = (cnt_ff == top);
        if (cnt_ff == top) begin
          run_cnt = `T2_BOTTOM;
          bottom_evt = 1'b1;
        end
      end
      timer2_pkg::WAVE_PHASE: begin
        run_up = up_ff;
        if (up_ff && (cnt_ff == top)) begin
          run_up = 1'b0;
          run_cnt = cnt_ff - 8'h01;
        end else if (!up_ff && (cnt_ff == `T2_BOTTOM)) begin
          run_up = 1'b1;
          ovf = 1'b1;
        end else if (!up_ff) begin
          run_cnt = cnt_ff - 8'h01;
        end
      end
      default: begin
        run_cnt = cnt_ff;
      end
    endcase
  end

  // Software writes and asynchronous loads.
  // In asynchronous mode a write only lands in the temporary copy; the active
  // copy follows on the next synchronised oscillator edge, which also clears busy.
  // Writing while busy overwrites the temporary copy, and the later value wins.
  wire as_now = async_sel_ff;
  wire w_ca = wr && hit_ca;
  wire w_cb = wr && hit_cb;
  wire w_cnt = wr && hit_cnt;
  wire w_oa = wr && hit_oa;
  wire w_ob = wr && hit_ob;
  wire [4:0] wr_vec = {w_cnt, w_oa, w_ob, w_ca, w_cb};
  wire [4:0] load_vec = as_now ? (busy_ff & {5{src_tick}}) : wr_vec;
  wire [4:0] nxt_busy = as_now ? ((busy_ff & ~load_vec) | wr_vec) : 5'b00000;
  wire [7:0] cnt_src = as_now ? tmp_cnt_ff : wd;
  wire [7:0] oa_src = as_now ? tmp_oa_ff : wd;
  wire [7:0] ob_src = as_now ? tmp_ob_ff : wd;
  wire [7:0] ca_src = as_now ? tmp_ca_ff : (wd & `T2_CTRLA_RW_MASK);
  wire [7:0] cb_src = as_now ? tmp_cb_ff : (wd & `T2_CTRLB_RW_MASK);

  // Force strobes act only in non-PWM modes and touch nothing but the pins.
  // They reuse the non-PWM match path so the pin follows the active mode bits.
  wire force_a = w_cb && wd[`T2_CTRLB_FORCE_A] && non_pwm;
  wire force_b = w_cb && wd[`T2_CTRLB_FORCE_B] && non_pwm;

  function automatic logic pin_next(input logic pin, input logic [1:0] com, input timer2_pkg::wave_kind_t k,
                                    input logic match, input logic frc, input logic bot, input logic up,
                                    input logic tog_ok);
    logic r;
    r = pin;
    case (k)
      timer2_pkg::WAVE_NORMAL, timer2_pkg::WAVE_CTC: begin
        if (match || frc) begin
          case (com)
            2'b01: r = !pin;
            2'b10: r = 1'b0;
            2'b11: r = 1'b1;
            default: r = pin;
          endcase
        end
      end
      timer2_pkg::WAVE_FAST: begin
        if (com[1] && bot) begin
          r = !com[0];
        end else if (com[1] && match) begin
          r = com[0];
        end else if ((com == 2'b01) && tog_ok && match) begin
          r = !pin;
        end
      end
      default: begin
        if (com[1] && match) begin
          r = up ? com[0] : !com[0];
        end else if ((com == 2'b01) && tog_ok && match) begin
          r = !pin;
        end
      end
    endcase
    return r;
  endfunction

  timer2_pkg::wave_pins_t nxt_pins;
  assign nxt_pins.pin_a = pin_next(pins_ff.pin_a, ca.com_a, kind, match_a, force_a, tick && bottom_evt, up_ff,
                                   wgm[2]);
  assign nxt_pins.pin_b = pin_next(pins_ff.pin_b, ca.com_b, kind, match_b, force_b, tick && bottom_evt, up_ff,
                                   1'b0);

  // Interrupt flags: hardware set wins over either clear.
  // A clear and a set in the same cycle leave the flag set so no event is lost.
  wire [2:0] set_vec = {match_b, match_a, tick && ovf};
  wire [2:0] sw_clr = (wr && hit_flags) ? wd[2:0] : 3'b000;
  wire [2:0] ack_clr = (wr && hit_cpu) ? wd[`T2_CPU_ACK_LSB+2:`T2_CPU_ACK_LSB] : 3'b000;
  wire [2:0] nxt_flags = (flags_ff & ~(sw_clr | ack_clr)) | set_vec;
  wire [2:0] irq_vec = flags_ff & mask_ff & {3{global_ie_ff}};

  wire [7:0] nxt_cnt = load_vec[4] ? cnt_src : (tick ? run_cnt : cnt_ff);
  wire nxt_block = load_vec[4] ? 1'b1 : (tick ? 1'b0 : block_ff);

  // Read data, captured in the setup phase.
  // Capturing in setup keeps prdata stable for the whole access phase.
  wire [7:0] async_rd = {1'b0, ext_clk_ff, async_sel_ff, busy_ff};
  wire [7:0] rd_byte = hit_mask ? {5'b00000, mask_ff} :
                       hit_flags ? {5'b00000, flags_ff} :
                       hit_ca ? tmp_ca_ff :
                       hit_cb ? (tmp_cb_ff & `T2_CTRLB_RW_MASK) :
                       hit_cnt ? cnt_ff :
                       hit_oa ? tmp_oa_ff :
                       hit_ob ? tmp_ob_ff :
                       hit_as ? async_rd :
                       hit_cpu ? {7'b0000000, global_ie_ff} : `T2_RESET_BYTE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= {24'h00_0000, rd_byte};
      pslverr_ff <= !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmp_ca_ff <= `T2_RESET_BYTE;
      tmp_cb_ff <= `T2_RESET_BYTE;
      tmp_oa_ff <= `T2_RESET_BYTE;
      tmp_ob_ff <= `T2_RESET_BYTE;
      tmp_cnt_ff <= `T2_RESET_BYTE;
    end else begin
      if (w_ca) tmp_ca_ff <= wd & `T2_CTRLA_RW_MASK;
      if (w_cb) tmp_cb_ff <= wd & `T2_CTRLB_RW_MASK;
      if (w_oa) tmp_oa_ff <= wd;
      if (w_ob) tmp_ob_ff <= wd;
      if (w_cnt) tmp_cnt_ff <= wd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ca_ff <= `T2_RESET_BYTE;
      act_cb_ff <= `T2_RESET_BYTE;
      act_oa_ff <= `T2_RESET_BYTE;
      act_ob_ff <= `T2_RESET_BYTE;
      busy_ff <= 5'b00000;
    end else begin
      if (load_vec[1]) act_ca_ff <= ca_src;
      if (load_vec[0]) act_cb_ff <= cb_src;
      if (load_vec[3]) act_oa_ff <= oa_src;
      if (load_vec[2]) act_ob_ff <= ob_src;
      busy_ff <= nxt_busy;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= `T2_RESET_BYTE;
      up_ff <= 1'b1;
      block_ff <= 1'b0;
      presc_ff <= '0;
      pins_ff <= '0;
      flags_ff <= 3'b000;
    end else begin
      cnt_ff <= nxt_cnt;
      up_ff <= tick ? run_up : up_ff;
      block_ff <= nxt_block;
      presc_ff <= (src_tick && (cs != 3'd0)) ? presc_ff + 1'b1 : presc_ff;
      pins_ff <= nxt_pins;
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= 3'b000;
      global_ie_ff <= 1'b0;
      ext_clk_ff <= 1'b0;
      async_sel_ff <= 1'b0;
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end else begin
      if (wr && hit_mask) mask_ff <= wd[2:0];
      if (wr && hit_cpu) global_ie_ff <= wd[`T2_CPU_GLOBAL_IE];
      if (wr && hit_as) ext_clk_ff <= wd[`T2_ASYNC_EXT_CLK];
      if (wr && hit_as) async_sel_ff <= wd[`T2_ASYNC_SELECT];
      osc_s1_ff <= timer_osc_input_pin;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = pslverr_ff && psel && penable;
  assign compare_output_pin_a = pins_ff.pin_a;
  assign compare_output_pin_b = pins_ff.pin_b;
  // Pin-connected flags follow the active mode bits and tell the port to yield.
  assign compare_a_pin_connected = (ca.com_a != 2'b00);
  assign compare_b_pin_connected = (ca.com_b != 2'b00);
  assign ext_clock_buffer_enable = ext_clk_ff && async_sel_ff;
  assign crystal_osc_enable = !ext_clk_ff;
  assign irq_overflow = irq_vec[`T2_IRQ_OVF];
  assign irq_compare_a = irq_vec[`T2_IRQ_CMP_A];
  assign irq_compare_b = irq_vec[`T2_IRQ_CMP_B];

endmodule

// >>> inc/timer2_defs.svh
// Purpose: Register indices, field positions, reset values and counts of the asynchronous timer.
// Assumes: A register's byte address is four times its index.
// Notes: Included by its bare name.
`ifndef TIMER2_DEFS_SVH
`define TIMER2_DEFS_SVH

`define T2_IDX_MASK 10'h070
`define T2_IDX_FLAGS 10'h037
`define T2_IDX_CTRL_A 10'h0b0
`define T2_IDX_CTRL_B 10'h0b1
`define T2_IDX_COUNT 10'h0b2
`define T2_IDX_CMP_A 10'h0b3
`define T2_IDX_CMP_B 10'h0b4
`define T2_IDX_ASYNC 10'h0b6
`define T2_IDX_CPU 10'h0b8

`define T2_CTRLB_FORCE_A 7
`define T2_CTRLB_FORCE_B 6
`define T2_CTRLB_WGM_HI 3
`define T2_CTRLB_RW_MASK 8'h0f
`define T2_CTRLA_RW_MASK 8'hf3

`define T2_IRQ_CMP_B 2
`define T2_IRQ_CMP_A 1
`define T2_IRQ_OVF 0
`define T2_IRQ_MASK 8'h07

`define T2_ASYNC_EXT_CLK 6
`define T2_ASYNC_SELECT 5
`define T2_BUSY_COUNT 4
`define T2_BUSY_CMP_A 3
`define T2_BUSY_CMP_B 2
`define T2_BUSY_CTRL_A 1
`define T2_BUSY_CTRL_B 0

`define T2_CPU_GLOBAL_IE 0
`define T2_CPU_ACK_LSB 1

`define T2_RESET_BYTE 8'h00
`define T2_MAX 8'hff
`define T2_BOTTOM 8'h00
`define T2_ADDR_W 12

`endif

// >>> inc/timer2_pkg.sv
// Purpose: Types shared by the asynchronous timer.
// Assumes: Constants live in timer2_defs.svh.
// Notes: None.
package timer2_pkg;

  typedef enum logic [1:0] {
    WAVE_NORMAL,
    WAVE_CTC,
    WAVE_FAST,
    WAVE_PHASE
  } wave_kind_t;

  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [1:0] rsvd;
    logic [1:0] wgm_lo;
  } ctrl_a_t;

  typedef struct packed {
    logic pin_a;
    logic pin_b;
  } wave_pins_t;

endpackage

// >>> dv/async_timer2_asserts.sv
// Purpose: Port-level assertions for the asynchronous timer.
// Assumes: Bound into async_timer2; one clock domain.
// Notes: A helper flop tracks whether the timer runs from the oscillator pin.
`timescale 1ns/1ps
`include "timer2_defs.svh"
module async_timer2_asserts #(
  parameter int PRESC_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`T2_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic compare_a_pin_connected,
  input wire logic ext_clock_buffer_enable,
  input wire logic crystal_osc_enable,
  input wire logic irq_compare_a,
  input wire logic irq_compare_b,
  input wire logic irq_overflow
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && paddr[1:0] == 2'h0;
  wire logic [9:0] idx = paddr[11:2];
  wire logic wr_async = acc && pwrite && idx == `T2_IDX_ASYNC;
  wire logic wr_ctla = acc && pwrite && idx == `T2_IDX_CTRL_A;
  wire logic no_irq = !irq_compare_a && !irq_compare_b && !irq_overflow;
  logic async_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_ff <= 1'b0;
    end else if (wr_async) begin
      async_ff <= pwdata[5];
    end
  end
  xtal_run_a: assert property (wr_async && !pwdata[6] |=> crystal_osc_enable)
    else $error("Crystal stopped while external clock is off.");
  ext_buf_a: assert property (wr_async && pwdata[6:5] == 2'h3 |=> ext_clock_buffer_enable && !crystal_osc_enable)
    else $error("External clock buffer not enabled.");
  buf_off_a: assert property (wr_async && !pwdata[5] |=> !ext_clock_buffer_enable)
    else $error("External buffer on with I/O clock selected.");
  force_read_a: assert property (acc && !pwrite && idx == `T2_IDX_CTRL_B |-> prdata[7:4] == 4'h0)
    else $error("Control B upper bits read nonzero.");
  async_top_a: assert property (acc && !pwrite && idx == `T2_IDX_ASYNC |-> !prdata[7])
    else $error("Status bit 7 read nonzero.");
  mask_off_a: assert property (acc && pwrite && idx == `T2_IDX_MASK && pwdata[2:0] == 3'h0 |=> ##1 no_irq)
    else $error("Interrupt raised with all enables clear.");
  gie_off_a: assert property (acc && pwrite && idx == `T2_IDX_CPU && !pwdata[0] |=> ##1 no_irq)
    else $error("Interrupt raised with global enable clear.");
  pin_off_a: assert property (wr_ctla && !async_ff && pwdata[7:6] == 2'h0 |=> !compare_a_pin_connected)
    else $error("Pin A connected with mode bits zero.");
  pin_on_a: assert property (wr_ctla && !async_ff && pwdata[7:6] != 2'h0 |=> compare_a_pin_connected)
    else $error("Pin A not connected.");
  cover property (wr_async && pwdata[5]);
  cover property (acc && pwrite && idx == `T2_IDX_CTRL_B && pwdata[7]);
  cover property ($rose(irq_overflow));
endmodule
bind async_timer2 async_timer2_asserts #(.PRESC_W(PRESC_W)) u_async_timer2_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .compare_a_pin_connected(compare_a_pin_connected), .ext_clock_buffer_enable(ext_clock_buffer_enable),
  .crystal_osc_enable(crystal_osc_enable), .irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b),
  .irq_overflow(irq_overflow));

// >>> dv/tb_async_timer2.sv
// Purpose: Self-checking bench for the asynchronous timer.
// Assumes: APB zero wait state; oscillator pin driven by the bench.
// Notes: Timer is stopped before flags are judged.
`timescale 1ns/1ps
`include "timer2_defs.svh"
module tb_async_timer2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic osc = 1'b0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err, pin_a, xtal, irq_a, irq_b, irq_o, p;
  int fail_count = 0;
  int checks_done = 0;
  int dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  always #10 pclk = ~pclk;
  async_timer2 #(.PRESC_W(10)) u_async_timer2 (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_osc_input_pin(osc), .compare_output_pin_a(pin_a), .compare_output_pin_b(),
    .compare_a_pin_connected(), .compare_b_pin_connected(), .ext_clock_buffer_enable(),
    .crystal_osc_enable(xtal), .irq_compare_a(irq_a), .irq_compare_b(irq_b), .irq_overflow(irq_o));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      give_verdict();
    end
    @(posedge pclk);
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask
  task automatic rd(input logic [9:0] i);
    xfer(1'b0, i, 8'h00);
  endtask
  task automatic chk(input logic [31:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== {24'h00_0000, exp}) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    @(negedge pclk);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
    @(posedge pclk);
  endtask
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic t_regs();
    rd(`T2_IDX_ASYNC);
    chk(q, 8'h00);
    chk_bit(xtal, 1'b1);
    wr(`T2_IDX_CMP_A, 8'ha5);
    rd(`T2_IDX_CMP_A);
    chk(q, 8'ha5);
    wr(`T2_IDX_CTRL_B, 8'hf8);
    rd(`T2_IDX_CTRL_B);
    chk(q, 8'h08);
    wr(`T2_IDX_CTRL_B, 8'h00);
    wr(`T2_IDX_ASYNC, 8'hff);
    rd(`T2_IDX_ASYNC);
    chk(q, 8'h60);
    wr(`T2_IDX_ASYNC, 8'h00);
    rd(10'h001);
    chk_bit(err, 1'b1);
    $display("register test done");
  endtask
  task automatic t_clock();
    for (int c = 1; c < 8; c++) begin
      wr(`T2_IDX_COUNT, 8'h00);
      wr(`T2_IDX_CTRL_B, {5'h00, 3'(c)});
      repeat (3 * dv[c]) @(posedge pclk);
      wr(`T2_IDX_CTRL_B, 8'h00);
      rd(`T2_IDX_COUNT);
      chk_rng(q, (3 * dv[c] + 3) / dv[c] - 1, (3 * dv[c] + 3) / dv[c] + 1);
    end
    wr(`T2_IDX_COUNT, 8'h77);
    repeat (20) @(posedge pclk);
    rd(`T2_IDX_COUNT);
    chk(q, 8'h77);
    $display("clock select test done");
  endtask
  task automatic run(input logic [7:0] start);
    wr(`T2_IDX_COUNT, start);
    wr(`T2_IDX_CTRL_B, 8'h01);
    repeat (8) @(posedge pclk);
    wr(`T2_IDX_CTRL_B, 8'h00);
    rd(`T2_IDX_FLAGS);
  endtask
  task automatic t_flags();
    wr(`T2_IDX_MASK, 8'h07);
    wr(`T2_IDX_CPU, 8'h01);
    wr(`T2_IDX_CMP_A, 8'h40);
    wr(`T2_IDX_CMP_B, 8'h80);
    run(8'hfc);
    chk(q, 8'h01);
    chk_bit(irq_o, 1'b1);
    wr(`T2_IDX_FLAGS, 8'h00);
    rd(`T2_IDX_FLAGS);
    chk(q, 8'h01);
    wr(`T2_IDX_FLAGS, 8'h01);
    rd(`T2_IDX_FLAGS);
    chk(q, 8'h00);
    wr(`T2_IDX_COUNT, 8'h40);
    wr(`T2_IDX_CTRL_B, 8'h01);
    wr(`T2_IDX_CTRL_B, 8'h00);
    rd(`T2_IDX_FLAGS);
    chk(q, 8'h00);
    run(8'h3c);
    chk(q, 8'h02);
    chk_bit(irq_a, 1'b1);
    wr(`T2_IDX_CPU, 8'h00);
    chk_bit(irq_a, 1'b0);
    wr(`T2_IDX_CPU, 8'h05);
    rd(`T2_IDX_FLAGS);
    chk(q, 8'h00);
    run(8'h7c);
    chk(q, 8'h04);
    chk_bit(irq_b, 1'b1);
    wr(`T2_IDX_FLAGS, 8'h04);
    rd(`T2_IDX_FLAGS);
    chk(q, 8'h00);
    $display("flag test done");
  endtask
  task automatic t_force();
    wr(`T2_IDX_CTRL_A, 8'h40);
    chk_bit(pin_a, 1'b0);
    p = pin_a;
    wr(`T2_IDX_CTRL_B, 8'h80);
    chk_bit(pin_a, ~p);
    wr(`T2_IDX_CTRL_A, 8'h42);
    wr(`T2_IDX_COUNT, 8'h55);
    wr(`T2_IDX_CTRL_B, 8'h80);
    chk_bit(pin_a, p);
    rd(`T2_IDX_COUNT);
    chk(q, 8'h55);
    rd(`T2_IDX_FLAGS);
    chk(q, 8'h00);
    wr(`T2_IDX_CTRL_A, 8'hc3);
    wr(`T2_IDX_CTRL_B, 8'h80);
    chk_bit(pin_a, p);
    wr(`T2_IDX_CTRL_B, 8'h00);
    $display("force test done");
  endtask
  task automatic t_async();
    int n;
    wr(`T2_IDX_ASYNC, 8'h40);
    wr(`T2_IDX_ASYNC, 8'h60);
    wr(`T2_IDX_CMP_B, 8'h33);
    wr(`T2_IDX_COUNT, 8'h10);
    wr(`T2_IDX_CTRL_A, 8'h00);
    wr(`T2_IDX_CTRL_B, 8'h00);
    rd(`T2_IDX_ASYNC);
    chk(q, 8'h77);
    rd(`T2_IDX_CMP_B);
    chk(q, 8'h33);
    osc <= 1'b1;
    n = 0;
    do begin
      rd(`T2_IDX_ASYNC);
      n++;
    end while (q[4:0] !== 5'h00 && n < 10);
    chk(q, 8'h60);
    osc <= 1'b0;
    $display("async test done");
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_clock();
    t_flags();
    t_force();
    t_async();
    give_verdict();
  end
endmodule
